// *** bench/sac_cmp_model.sv ***
// comparator and one selected analog input at the converter's far side
`timescale 1ns/100ps
module sac_cmp_model (
  input wire logic [7:0] level,
  input wire logic [7:0] dac_code,
  input wire logic power,
  output logic cmp_high
);
  // single input, power only
  // one input level only; unpowered comparator gives a fixed low
  assign cmp_high = power && (level >= dac_code);
endmodule // sac_cmp_model

// *** bench/sac_top_asserts.sv ***
// checker of the conversion control ports, bound into sac_top
`timescale 1ns/100ps
module sac_top_asserts
  import sac_pkg::*;
#(
  parameter int TICK_CYC = SAC_TICK_CYC,
  parameter int CONV_TICKS = SAC_CONV_TICKS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic converter_power,
  input wire logic conversion_irq,
  input wire logic sample_active,
  input wire logic [7:0] dac_code
);
  localparam int HI = TICK_CYC * (CONV_TICKS + 1);
  localparam int LO = TICK_CYC * (CONV_TICKS - 1);
  logic [15:0] run_cnt;
  wire start = wr && addr == SAC_ADDR_CTRL && wdata[SAC_BIT_START];
  // run length; a restart begins the count anew
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_cnt <= '0;
    end else begin
      run_cnt <= (!sample_active || start) ? '0 : run_cnt + 16'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_power_follow: assert property (wr && addr == 8'hd1
    |=> converter_power == $past(wdata[4])) else $error("power bit lost");
  a_start_run: assert property (start
    |=> sample_active && dac_code == 8'h80 && !conversion_irq)
    else $error("start not taken");
  a_start_reads0: assert property (rd && addr == 8'hd1
    |=> !rdata[5]) else $error("start bit read as one");
  a_single_shot: assert property (!sample_active && !wr
    |=> !sample_active) else $error("conversion without start");
  a_power_idle: assert property (!converter_power && !wr
    |=> !sample_active) else $error("running while unpowered");
  a_irq_idle: assert property (conversion_irq
    |-> !sample_active) else $error("irq during conversion");
  a_run_long: assert property (sample_active
    |-> run_cnt < HI) else $error("conversion too long");
  a_run_short: assert property ($fell(sample_active) && converter_power
    |-> $past(run_cnt) >= LO) else $error("conversion too short");
endmodule // sac_top_asserts

bind sac_top sac_top_asserts #(.TICK_CYC(TICK_CYC), .CONV_TICKS(CONV_TICKS))
  sac_top_asserts_i (.clk(clk), .arst_n(arst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .converter_power(converter_power), .conversion_irq(conversion_irq),
  .sample_active(sample_active), .dac_code(dac_code));

// *** bench/test_sac_top.sv ***
// self-checking testbench of the conversion control block
`timescale 1ns/100ps
module test_sac_top;
  logic clk = 0, arst_n = 0, wr = 0, rd = 0, core_wait = 0;
  logic [7:0] addr = '0, wdata = '0, level = '0, rdata, dac_code, r;
  logic cmp_high, converter_power, conversion_irq, sample_active;
  int n_errors = 0, n_tests = 0;
  // rows: core_wait, analog level, expected result
  logic [16:0] rows [4] = '{17'h00000, 17'h1ffff, 17'h0a5a5, 17'h17f7f};
  sac_top #(.TICK_CYC(4), .CONV_TICKS(10)) sac_top_i (.clk(clk),
    .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cmp_high(cmp_high), .core_wait(core_wait),
    .dac_code(dac_code), .converter_power(converter_power),
    .conversion_irq(conversion_irq), .sample_active(sample_active));
  sac_cmp_model sac_cmp_model_i (.level(level), .dac_code(dac_code),
    .power(converter_power), .cmp_high(cmp_high));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe; taken at the
  // edge that closes that cycle, before the port drops them to zero
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    r = rdata;
  endtask
  task automatic wait_idle;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 200 && sample_active !== 1'b0; k++) @(posedge clk);
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    n_errors++;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(8'hd1);
    chk(r, 8'h40);
    wr_reg(8'hd1, 8'h80);
    rd_reg(8'hd1);
    chk({7'h0, conversion_irq}, 8'h01);
    wr_reg(8'hd1, 8'h00);
    rd_reg(8'hd1);
    chk({7'h0, conversion_irq}, 8'h00);
    foreach (rows[i]) begin
      core_wait <= rows[i][16];
      level <= rows[i][15:8];
      wr_reg(8'hd1, 8'h90);
      wr_reg(8'hd1, 8'hb0);
      rd_reg(8'hd1);
      chk(r, 8'h90);
      chk({7'h0, converter_power}, 8'h01);
      wait_idle;
      rd_reg(8'hd0);
      chk(r, rows[i][7:0]);
      rd_reg(8'hd1);
      chk(r, 8'hd0);
      chk({7'h0, conversion_irq}, 8'h01);
    end
    // restart in mid-run: only the second level may show
    level <= 8'h3c;
    wr_reg(8'hd1, 8'hb0);
    repeat (12) @(posedge clk);
    level <= 8'hc3;
    wr_reg(8'hd1, 8'hb0);
    wait_idle;
    wr_reg(8'hd0, 8'h00);
    rd_reg(8'hd0);
    chk(r, 8'hc3);
    rd_reg(8'h55);
    chk(r, 8'h00);
    wr_reg(8'hd1, 8'h30);
    repeat (5) @(posedge clk);
    wr_reg(8'hd1, 8'h00);
    rd_reg(8'hd1);
    chk({7'h0, sample_active}, 8'h00);
    chk(r, 8'h00);
    wr_reg(8'hd1, 8'hb0);
    repeat (5) @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(8'hd1);
    chk(r, 8'h40);
    chk({7'h0, sample_active}, 8'h00);
    end_of_test;
  end
endmodule // test_sac_top

// *** hw/sac_pkg.sv ***
// package of constants and types for the successive-approximation converter control
//
// Contract
// - sequencer clocked by oscillator divided by twelve
// - eight-bit result resolved msb to lsb
// - about 70us per conversion at 8MHz
// - start bit begins conversion, clears completion flag
// - completion flag set when conversion ends
// - one conversion per start, never continuous
// - start during conversion restarts from scratch
// - start bit always reads as zero
// - completion raises end-of-conversion interrupt vector 4
// - interrupt passed only while enable bit set
// - converter powered only while power select one
// - wait mode does not switch comparator off
// - reset aborts conversion, control reads 40h
// - control register at d1h, fixed bit layout
// - read-only result register at d0h
package sac_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] SAC_ADDR_DATA = 8'hd0;
  localparam logic [7:0] SAC_ADDR_CTRL = 8'hd1;
  localparam logic [7:0] SAC_CTRL_RESET = 8'h40;

  // control register fields
  localparam int SAC_BIT_IRQ_EN = 7;
  localparam int SAC_BIT_DONE = 6;
  localparam int SAC_BIT_START = 5;
  localparam int SAC_BIT_POWER = 4;

  // ==========================================================
  // timing
  localparam int SAC_CLK_MHZ = 100;
  localparam int SAC_OSC_MHZ = 8;
  localparam int SAC_OSC_DIV = 12;
  localparam int SAC_CONV_US = 70;
  // conversion clocks per conversion: 70us * 8MHz / 12, rounded down
  localparam int SAC_CONV_TICKS = SAC_CONV_US * SAC_OSC_MHZ / SAC_OSC_DIV;
  // system clocks per conversion tick: 100MHz * 12 / 8MHz, exact;
  // dividing first would truncate 12.5 and run the ticks fast
  localparam int SAC_TICK_CYC = SAC_CLK_MHZ * SAC_OSC_DIV / SAC_OSC_MHZ;
  localparam int SAC_BITS = 8;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_SETTLE = 2'b01,
    SAC_TRIAL = 2'b11
  } sac_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sac_bus_req_t;

endpackage

// *** hw/sac_tick_div.sv ***
// divider making the conversion clock tick from the system clock
`timescale 1ns/100ps
module sac_tick_div
  import sac_pkg::*;
#(
  parameter int DIV = SAC_TICK_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clear,
  output logic tick
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;

  // ==========================================================
  // counter, restarted with each conversion so ticks stay aligned
  always_comb begin
    next_cnt = cnt + 16'h0001;
    if (clear || cnt == 16'(DIV - 1)) begin
      next_cnt = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign tick = !clear && cnt == 16'(DIV - 1);
endmodule // sac_tick_div

// *** hw/sac_top.sv ***
// conversion control block: register port, sequencer, interrupt
`timescale 1ns/100ps
module sac_top
  import sac_pkg::*;
#(
  parameter int TICK_CYC = SAC_TICK_CYC,
  parameter int CONV_TICKS = SAC_CONV_TICKS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic cmp_high,
  input wire logic core_wait,
  output logic [7:0] dac_code,
  output logic converter_power,
  output logic conversion_irq,
  output logic sample_active
);
  sac_bus_req_t req;
  sac_state_t state, next_state;
  logic conversion_irq_enable, next_irq_en;
  logic converter_power_select, next_power;
  logic done, next_done;
  logic [7:0] result, next_result;
  logic [7:0] trial, next_trial;
  logic [3:0] bit_idx, next_bit_idx;
  logic [7:0] tcnt, next_tcnt;
  logic [7:0] next_rdata;
  logic start_wr;
  logic tick;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // ==========================================================
  // decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  assign start_wr = req.wr && hit(req.addr, SAC_ADDR_CTRL)
    && req.wdata[SAC_BIT_START];

  sac_tick_div #(.DIV(TICK_CYC)) u_div (
    .clk(clk),
    .arst_n(arst_n),
    .clear(start_wr),
    .tick(tick)
  );

  // ==========================================================
  // sequencer: settle ticks, then one tick per bit decision;
  // the comparator input is sampled on each decision tick
  always_comb begin
    next_state = state;
    next_trial = trial;
    next_bit_idx = bit_idx;
    next_tcnt = tcnt;
    next_result = result;
    next_done = done;
    next_irq_en = conversion_irq_enable;
    next_power = converter_power_select;
    if (req.wr && hit(req.addr, SAC_ADDR_CTRL)) begin
      next_irq_en = req.wdata[SAC_BIT_IRQ_EN];
      next_power = req.wdata[SAC_BIT_POWER];
    end
    case (state)
      SAC_IDLE: begin
      end
      SAC_SETTLE: begin
        if (tick) begin
          next_tcnt = tcnt + 8'h01;
          if (tcnt == 8'(CONV_TICKS - SAC_BITS - 1)) begin
            next_state = SAC_TRIAL;
          end
        end
      end
      SAC_TRIAL: begin
        if (tick) begin
          // keep or drop trial bit, msb first
          if (!cmp_high) begin
            next_trial[3'(bit_idx)] = 1'b0;
          end
          if (bit_idx != 4'h0) begin
            next_trial[3'(bit_idx - 4'h1)] = 1'b1;
            next_bit_idx = bit_idx - 4'h1;
          end else begin
            next_result = next_trial;
            next_done = 1'b1;
            next_state = SAC_IDLE;
          end
        end
      end
      default: next_state = SAC_IDLE;
    endcase
    if (!converter_power_select) begin
      next_state = SAC_IDLE;
    end
    if (start_wr) begin
      next_state = SAC_SETTLE;
      next_tcnt = 8'h00;
      next_trial = 8'h80;
      next_bit_idx = 4'(SAC_BITS - 1);
      next_done = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= SAC_IDLE;
      trial <= 8'h00;
      bit_idx <= 4'h0;
      tcnt <= 8'h00;
      result <= 8'h00;
      done <= SAC_CTRL_RESET[SAC_BIT_DONE];
      conversion_irq_enable <= SAC_CTRL_RESET[SAC_BIT_IRQ_EN];
      converter_power_select <= SAC_CTRL_RESET[SAC_BIT_POWER];
    end else begin
      state <= next_state;
      trial <= next_trial;
      bit_idx <= next_bit_idx;
      tcnt <= next_tcnt;
      result <= next_result;
      done <= next_done;
      conversion_irq_enable <= next_irq_en;
      converter_power_select <= next_power;
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (req.rd) begin
      if (hit(req.addr, SAC_ADDR_CTRL)) begin
        next_rdata[SAC_BIT_IRQ_EN] = conversion_irq_enable;
        next_rdata[SAC_BIT_DONE] = done;
        next_rdata[SAC_BIT_START] = 1'b0;
        next_rdata[SAC_BIT_POWER] = converter_power_select;
      end else if (hit(req.addr, SAC_ADDR_DATA)) begin
        next_rdata = result;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // outputs
  // power ignores wait; core_wait deliberately unused here
  assign converter_power = converter_power_select | (core_wait & 1'b0);
  assign conversion_irq = done & conversion_irq_enable;
  assign dac_code = trial;
  assign sample_active = state != SAC_IDLE;
endmodule // sac_top
